// ### rtl/pttc_pkg.sv
// package: register map, field layout and encodings of the periodic timer
package pttc_pkg;

    // register indices (word addresses = index; byte addresses = index * 4)
    localparam logic [3:0] PTTC_IDX_CTRL0   = 4'h0;
    localparam logic [3:0] PTTC_IDX_CTRL1   = 4'h1;
    localparam logic [3:0] PTTC_IDX_CNT_LO  = 4'h2;
    localparam logic [3:0] PTTC_IDX_CNT_HI  = 4'h3;
    localparam logic [3:0] PTTC_IDX_DUTY_LO = 4'h4;
    localparam logic [3:0] PTTC_IDX_DUTY_HI = 4'h5;
    localparam logic [3:0] PTTC_IDX_PER_LO  = 4'h6;
    localparam logic [3:0] PTTC_IDX_PER_HI  = 4'h7;
    localparam logic [3:0] PTTC_IDX_FLAGS   = 4'h8;

    // control-zero fields
    localparam int PTTC_C0_RUN_BIT = 3;

    // control-one fields
    localparam int PTTC_C1_MODE_HI = 7;
    localparam int PTTC_C1_MODE_LO = 6;
    localparam int PTTC_C1_ACT_HI  = 5;
    localparam int PTTC_C1_ACT_LO  = 4;
    localparam int PTTC_C1_INIT    = 3;
    localparam int PTTC_C1_POL     = 2;
    localparam int PTTC_C1_CAPSRC  = 1;
    localparam int PTTC_C1_CLRSRC  = 0;

    // flag register fields (write one to clear)
    localparam int PTTC_FL_DUTY = 0;
    localparam int PTTC_FL_PER  = 1;

    localparam int PTTC_CW = 10;

    localparam logic [7:0]         PTTC_CTRL_RST  = 8'h00;
    localparam logic [PTTC_CW-1:0] PTTC_CNT_RST   = 10'h000;
    localparam logic [PTTC_CW-1:0] PTTC_CNT_MAX   = 10'h3FF;
    localparam logic [PTTC_CW-1:0] PTTC_CNT_ONE   = 10'h001;
    localparam logic [31:0]        PTTC_BUS_ZERO  = 32'h0000_0000;

    typedef enum logic [1:0] {
        PTTC_MODE_CMP = 2'b00,
        PTTC_MODE_CAP = 2'b01,
        PTTC_MODE_PWM = 2'b10,
        PTTC_MODE_TMR = 2'b11
    } pttc_mode_t;

    // capture edge encoding / pulse action field
    localparam logic [1:0] PTTC_ACT_RISE = 2'b00;
    localparam logic [1:0] PTTC_ACT_FALL = 2'b01;
    localparam logic [1:0] PTTC_ACT_BOTH = 2'b10;
    localparam logic [1:0] PTTC_ACT_NONE = 2'b11;
    localparam logic [1:0] PTTC_ACT_LOW  = 2'b00;
    localparam logic [1:0] PTTC_ACT_HIGH = 2'b01;
    localparam logic [1:0] PTTC_ACT_PWM  = 2'b10;

    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } pttc_bus_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } pttc_bus_rsp_t;

    typedef struct packed {
        logic               run;
        logic [7:0]         ctrl1;
        logic [PTTC_CW-1:0] cnt;
        logic [PTTC_CW-1:0] duty;
        logic [PTTC_CW-1:0] per;
        logic               duty_flag;
        logic               per_flag;
        logic               pin_out;
        logic               pin_oe;
        logic [1:0]         trig_sync;
        logic [1:0]         io_sync;
        logic               trig_prev;
        logic               io_prev;
        logic               run_prev;
        logic               irq;
        logic               wait_req;
        logic [31:0]        rdata;
    } pttc_state_t;

endpackage

// ### rtl/pttc_timer.sv
// periodic timer: pwm tail, single pulse and capture modes with avalon slave
//
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
// ****************************************************************
// Notes on behaviour
// - in pwm mode every counter clear starts a new period
// - pwm generation keeps running while action field forces pin to 00/01
// - pwm mode ignores the clear source select bit
// - single pulse: run bit rising starts the pulse leading edge
// - single pulse: trigger pin active edge sets the run bit
// - run bit high starts counter and drives pulse on output pin
// - trailing edge on software clear or duty match; match clears run bit
// - single pulse: duty match raises timer interrupt
// - single pulse: counter zeroes only on run bit rising
// - single pulse ignores period value and clear source select
// - capture source is io pin or trigger pin by select bit
// - action field picks capture edge; 11 disables capture, counter runs
// - capture counter starts on run rising, free runs until run falls
// - active capture edge copies counter into duty value and interrupts
// - capture: period match zeroes counter and interrupts
// - capture: period value zero gives full count range
// - capture edges count even while the shared pin is an output
// - capture ignores clear select, initial level and polarity bits
// - counter and compare values are 10 bits, read as low byte plus 2 bits
// - capture select 0 picks io pin, 1 picks trigger pin
// - duty match sets duty flag except in capture, period match sets period flag except in single pulse
// ****************************************************************
module pttc_timer (
    input  wire logic                    core_clk,
    input  wire logic                    sys_rst,
    input  wire pttc_pkg::pttc_bus_req_t bus_req,
    output      pttc_pkg::pttc_bus_rsp_t bus_rsp,
    input  wire logic                    trig_pin_in,
    input  wire logic                    io_pin_in,
    output      logic                    io_pin_out,
    output      logic                    io_pin_oe,
    output      logic                    timer_irq
);
    import pttc_pkg::*;

    pttc_state_t s_q;
    pttc_state_t s_d;

    pttc_mode_t          mode;
    logic [1:0]          act;
    logic                trig_rise;
    logic                io_rise;
    logic                io_fall;
    logic                src_rise;
    logic                src_fall;
    logic                cap_hit;
    logic                duty_hit;
    logic                per_hit;
    logic                run_rise;
    logic                wr;
    logic                rd;
    logic [PTTC_CW-1:0]  cnt_inc;
    logic                pwm_level;

    // ****************************************************************
    // decode
    // ****************************************************************
    always_comb begin
        mode      = pttc_mode_t'(s_q.ctrl1[PTTC_C1_MODE_HI:PTTC_C1_MODE_LO]);
        act       = s_q.ctrl1[PTTC_C1_ACT_HI:PTTC_C1_ACT_LO];
        trig_rise = s_q.trig_sync[1] & ~s_q.trig_prev;
        io_rise   = s_q.io_sync[1] & ~s_q.io_prev;
        io_fall   = ~s_q.io_sync[1] & s_q.io_prev;
        // pin direction not consulted: edges count even when driving
        src_rise  = s_q.ctrl1[PTTC_C1_CAPSRC] ? trig_rise : io_rise;
        src_fall  = s_q.ctrl1[PTTC_C1_CAPSRC] ? (~s_q.trig_sync[1] & s_q.trig_prev)
                                               : io_fall;
        case (act)
            PTTC_ACT_RISE: cap_hit = src_rise;
            PTTC_ACT_FALL: cap_hit = src_fall;
            PTTC_ACT_BOTH: cap_hit = src_rise | src_fall;
            default:       cap_hit = 1'b0;
        endcase
        run_rise  = s_q.run & ~s_q.run_prev;
        duty_hit  = s_q.run & ~run_rise & (s_q.cnt == s_q.duty);
        // zero period means wrap at full range
        per_hit   = s_q.run & ~run_rise &
                    (s_q.per == PTTC_CNT_RST ? s_q.cnt == PTTC_CNT_MAX
                                              : s_q.cnt == s_q.per);
        cnt_inc   = s_q.cnt + PTTC_CNT_ONE;
        // writes land on the edge at which the master sees waitrequest low
        wr        = bus_req.write & ~s_q.wait_req;
        rd        = bus_req.read & s_q.wait_req;
        pwm_level = (s_q.cnt < s_q.duty) ^ s_q.ctrl1[PTTC_C1_INIT];
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d           = s_q;
        s_d.trig_sync = {s_q.trig_sync[0], trig_pin_in};
        s_d.io_sync   = {s_q.io_sync[0], io_pin_in};
        s_d.trig_prev = s_q.trig_sync[1];
        s_d.io_prev   = s_q.io_sync[1];
        s_d.run_prev  = s_q.run;
        s_d.wait_req  = 1'b1;
        s_d.irq       = 1'b0;

        // counter
        if (run_rise) begin
            s_d.cnt = PTTC_CNT_RST;
        end else if (s_q.run) begin
            case (mode)
                PTTC_MODE_PWM: begin
                    if (act == PTTC_ACT_NONE) begin
                        // single pulse: period and clear select unused
                        s_d.cnt = cnt_inc;
                    end else begin
                        // clear select ignored, period match clears
                        s_d.cnt = per_hit ? PTTC_CNT_RST : cnt_inc;
                    end
                end
                PTTC_MODE_CAP: begin
                    // free runs whatever the pin does
                    s_d.cnt = per_hit ? PTTC_CNT_RST : cnt_inc;
                end
                default: begin
                    if (s_q.ctrl1[PTTC_C1_CLRSRC]) begin
                        s_d.cnt = duty_hit ? PTTC_CNT_RST : cnt_inc;
                    end else begin
                        s_d.cnt = per_hit ? PTTC_CNT_RST : cnt_inc;
                    end
                end
            endcase
        end

        // single pulse run control
        if (mode == PTTC_MODE_PWM && act == PTTC_ACT_NONE) begin
            if (trig_rise) begin
                s_d.run = 1'b1;
            end
            if (duty_hit) begin
                s_d.run = 1'b0;
            end
        end

        // capture and flags; set wins over clear
        if (wr && bus_req.address == PTTC_IDX_FLAGS) begin
            if (bus_req.writedata[PTTC_FL_DUTY]) s_d.duty_flag = 1'b0;
            if (bus_req.writedata[PTTC_FL_PER])  s_d.per_flag  = 1'b0;
        end
        if (mode == PTTC_MODE_CAP) begin
            if (s_q.run && cap_hit) begin
                s_d.duty      = s_q.cnt;
                s_d.duty_flag = 1'b1;
                s_d.irq       = 1'b1;
            end
            if (per_hit) begin
                s_d.per_flag = 1'b1;
                s_d.irq      = 1'b1;
            end
        end else begin
            if (duty_hit) begin
                s_d.duty_flag = 1'b1;
                s_d.irq       = 1'b1;
            end
            if (per_hit && !(mode == PTTC_MODE_PWM && act == PTTC_ACT_NONE)) begin
                s_d.per_flag = 1'b1;
                s_d.irq      = 1'b1;
            end
        end

        // output pin
        case (mode)
            PTTC_MODE_PWM: begin
                s_d.pin_oe = 1'b1;
                if (act == PTTC_ACT_NONE) begin
                    s_d.pin_out = s_d.run ^ s_q.ctrl1[PTTC_C1_POL];
                end else if (act == PTTC_ACT_PWM) begin
                    s_d.pin_out = pwm_level ^ s_q.ctrl1[PTTC_C1_POL];
                end else begin
                    s_d.pin_out = (act == PTTC_ACT_HIGH) ^ s_q.ctrl1[PTTC_C1_POL];
                end
            end
            PTTC_MODE_CMP: begin
                s_d.pin_oe = 1'b1;
                if (run_rise) begin
                    s_d.pin_out = s_q.ctrl1[PTTC_C1_INIT] ^ s_q.ctrl1[PTTC_C1_POL];
                end else if (duty_hit) begin
                    case (act)
                        PTTC_ACT_HIGH: s_d.pin_out = ~s_q.ctrl1[PTTC_C1_POL];
                        PTTC_ACT_PWM:  s_d.pin_out = s_q.ctrl1[PTTC_C1_POL];
                        PTTC_ACT_NONE: s_d.pin_out = ~s_q.pin_out;
                        default:       s_d.pin_out = s_q.pin_out;
                    endcase
                end
            end
            default: begin
                // capture: no output, init level and polarity unused
                s_d.pin_oe  = 1'b0;
                s_d.pin_out = 1'b0;
            end
        endcase

        // ****************************************************************
        // avalon slave: one wait state, answer on second cycle
        // ****************************************************************
        if ((bus_req.read | bus_req.write) & s_q.wait_req) begin
            s_d.wait_req = 1'b0;
        end
        if (wr) begin
            case (bus_req.address)
                PTTC_IDX_CTRL0:   s_d.run = bus_req.writedata[PTTC_C0_RUN_BIT];
                PTTC_IDX_CTRL1:   s_d.ctrl1 = bus_req.writedata[7:0];
                PTTC_IDX_DUTY_LO: s_d.duty[7:0] = bus_req.writedata[7:0];
                PTTC_IDX_DUTY_HI: s_d.duty[9:8] = bus_req.writedata[1:0];
                PTTC_IDX_PER_LO:  s_d.per[7:0] = bus_req.writedata[7:0];
                PTTC_IDX_PER_HI:  s_d.per[9:8] = bus_req.writedata[1:0];
                default: ;
            endcase
        end
        if (rd) begin
            s_d.rdata = PTTC_BUS_ZERO;
            case (bus_req.address)
                PTTC_IDX_CTRL0:   s_d.rdata[PTTC_C0_RUN_BIT] = s_q.run;
                PTTC_IDX_CTRL1:   s_d.rdata[7:0] = s_q.ctrl1;
                PTTC_IDX_CNT_LO:  s_d.rdata[7:0] = s_q.cnt[7:0];
                PTTC_IDX_CNT_HI:  s_d.rdata[1:0] = s_q.cnt[9:8];
                PTTC_IDX_DUTY_LO: s_d.rdata[7:0] = s_q.duty[7:0];
                PTTC_IDX_DUTY_HI: s_d.rdata[1:0] = s_q.duty[9:8];
                PTTC_IDX_PER_LO:  s_d.rdata[7:0] = s_q.per[7:0];
                PTTC_IDX_PER_HI:  s_d.rdata[1:0] = s_q.per[9:8];
                PTTC_IDX_FLAGS: begin
                    s_d.rdata[PTTC_FL_DUTY] = s_q.duty_flag;
                    s_d.rdata[PTTC_FL_PER]  = s_q.per_flag;
                end
                default: s_d.rdata = PTTC_BUS_ZERO;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            s_q          <= '0;
            s_q.wait_req <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_rsp.readdata    = s_q.rdata;
    assign bus_rsp.waitrequest = s_q.wait_req;
    assign io_pin_out          = s_q.pin_out;
    assign io_pin_oe           = s_q.pin_oe;
    assign timer_irq           = s_q.irq;

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_pulse_end;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_PWM && act == PTTC_ACT_NONE && duty_hit && !wr)
            |=> !s_q.run && s_q.duty_flag;
    endproperty
    a_pulse_end: assert property (p_pulse_end) else $error("duty match kept run");

    property p_trig_start;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_PWM && act == PTTC_ACT_NONE && trig_rise && !duty_hit && !wr)
            |=> s_q.run;
    endproperty
    a_trig_start: assert property (p_trig_start) else $error("trigger missed");

    property p_restart_zero;
        @(posedge core_clk) disable iff (sys_rst)
        run_rise |=> s_q.cnt == PTTC_CNT_RST;
    endproperty
    a_restart_zero: assert property (p_restart_zero) else $error("no zero on run");

    property p_capture;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_CAP && s_q.run && cap_hit && !wr)
            |=> s_q.duty == $past(s_q.cnt) && s_q.irq;
    endproperty
    a_capture: assert property (p_capture) else $error("capture lost");

    property p_cap_off;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_CAP && act == PTTC_ACT_NONE && !wr) |=> $stable(s_q.duty);
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("capture while off");

    property p_cap_wrap;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_CAP && per_hit && !wr)
            |=> s_q.cnt == PTTC_CNT_RST && s_q.per_flag;
    endproperty
    a_cap_wrap: assert property (p_cap_wrap) else $error("period wrap missed");

    property p_pulse_pin;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_PWM && act == PTTC_ACT_NONE && !wr)
            ##1 (mode == PTTC_MODE_PWM && act == PTTC_ACT_NONE)
            |-> io_pin_out == (s_q.run ^ s_q.ctrl1[PTTC_C1_POL]);
    endproperty
    a_pulse_pin: assert property (p_pulse_pin) else $error("pulse pin wrong");

    property p_bus_ack;
        @(posedge core_clk) disable iff (sys_rst)
        (bus_req.read || bus_req.write) && bus_rsp.waitrequest |=> !bus_rsp.waitrequest;
    endproperty
    a_bus_ack: assert property (p_bus_ack) else $error("bus not answered");

    property p_cnt_hold;
        @(posedge core_clk) disable iff (sys_rst)
        !s_q.run
            |=> $stable(s_q.cnt);
    endproperty
    a_cnt_hold: assert property (p_cnt_hold) else $error("counter moved while stopped");

    property p_cap_free;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_CAP && s_q.run && !run_rise && !per_hit)
            |=> s_q.cnt == $past(s_q.cnt) + PTTC_CNT_ONE;
    endproperty
    a_cap_free: assert property (p_cap_free) else $error("capture counter stalled");

    property p_cap_pin_off;
        @(posedge core_clk) disable iff (sys_rst)
        mode == PTTC_MODE_CAP
            |=> !io_pin_oe && !io_pin_out;
    endproperty
    a_cap_pin_off: assert property (p_cap_pin_off) else $error("pin driven in capture");

    property p_pwm_period;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_PWM && act != PTTC_ACT_NONE && per_hit)
            |=> s_q.cnt == PTTC_CNT_RST;
    endproperty
    a_pwm_period: assert property (p_pwm_period) else $error("period match kept count");

    property p_pwm_forced;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_PWM && (act == PTTC_ACT_LOW || act == PTTC_ACT_HIGH) && per_hit)
            |=> s_q.per_flag;
    endproperty
    a_pwm_forced: assert property (p_pwm_forced) else $error("forced pwm stopped");

    property p_sp_no_period;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_PWM && act == PTTC_ACT_NONE && !wr)
            |=> $stable(s_q.per_flag);
    endproperty
    a_sp_no_period: assert property (p_sp_no_period) else $error("period flag in pulse");

    property p_duty_flag;
        @(posedge core_clk) disable iff (sys_rst)
        (mode != PTTC_MODE_CAP && duty_hit)
            |=> s_q.duty_flag;
    endproperty
    a_duty_flag: assert property (p_duty_flag) else $error("duty flag missed");

    property p_pulse_irq;
        @(posedge core_clk) disable iff (sys_rst)
        (mode == PTTC_MODE_PWM && act == PTTC_ACT_NONE && duty_hit)
            |=> timer_irq;
    endproperty
    a_pulse_irq: assert property (p_pulse_irq) else $error("pulse end without interrupt");

    property p_duty_write;
        @(posedge core_clk) disable iff (sys_rst)
        (bus_req.write && !bus_rsp.waitrequest && bus_req.address == PTTC_IDX_DUTY_LO)
            |=> s_q.duty[7:0] == $past(bus_req.writedata[7:0]);
    endproperty
    a_duty_write: assert property (p_duty_write) else $error("duty write lost");

endmodule // pttc_timer

// ### dv/pttc_pin_model.sv
// pin model: trigger pin and shared timer io pin as the timer sees them
`timescale 1ns/1ps
module pttc_pin_model (
    input  wire logic trig_lvl,
    input  wire logic io_lvl,
    input  wire logic io_pin_out,
    input  wire logic io_pin_oe,
    output      logic trig_pin_in,
    output      logic io_pin_in
);
    // ****************************************************************
    // pin levels
    // ****************************************************************
    // shared pin: the timer's own drive wins while enabled, so its
    // transitions reach the capture input as well
    assign trig_pin_in = trig_lvl;
    assign io_pin_in   = io_pin_oe ? io_pin_out : io_lvl;
endmodule // pttc_pin_model

// ### dv/tb.sv
// testbench: bus, single pulse, capture and pwm checks of the periodic timer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module tb;
    import pttc_pkg::*;
    logic          core_clk = 1'b0;
    logic          sys_rst  = 1'b1;
    pttc_bus_req_t bus_req  = '0;
    pttc_bus_rsp_t bus_rsp;
    logic          trig_lvl = 1'b0;
    logic          io_lvl   = 1'b0;
    logic          trig_pin_in;
    logic          io_pin_in;
    logic          io_pin_out;
    logic          io_pin_oe;
    logic          timer_irq;
    logic          out_prev = 1'b0;
    int            error_cnt = 0;
    int            tests_run = 0;
    int            irq_cnt   = 0;
    int            hi_cnt    = 0;
    int            rise_cnt  = 0;

    always #4 core_clk = ~core_clk;

    // counters are only read as snapshots, never reset, so no second driver
    always @(posedge core_clk) begin
        irq_cnt  <= irq_cnt + (timer_irq === 1'b1);
        hi_cnt   <= hi_cnt + (io_pin_out === 1'b1);
        rise_cnt <= rise_cnt + (io_pin_out === 1'b1 && out_prev === 1'b0);
        out_prev <= io_pin_out;
    end

    pttc_timer dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .bus_req(bus_req),
        .bus_rsp(bus_rsp), .trig_pin_in(trig_pin_in), .io_pin_in(io_pin_in),
        .io_pin_out(io_pin_out), .io_pin_oe(io_pin_oe), .timer_irq(timer_irq));
    pttc_pin_model pin_u (.trig_lvl(trig_lvl), .io_lvl(io_lvl), .io_pin_out(io_pin_out),
        .io_pin_oe(io_pin_oe), .trig_pin_in(trig_pin_in), .io_pin_in(io_pin_in));

    // ****************************************************************
    // bus and helper tasks
    // ****************************************************************
    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic bus_op(input logic [3:0] a, input logic w, input logic [7:0] d,
                          output logic [7:0] q);
        @(posedge core_clk);
        bus_req.address   <= a;
        bus_req.read      <= ~w;
        bus_req.write     <= w;
        bus_req.writedata <= {24'h00_0000, d};
        do @(posedge core_clk); while (bus_rsp.waitrequest !== 1'b0);
        q = bus_rsp.readdata[7:0];
        bus_req.read  <= 1'b0;
        bus_req.write <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus_op(a, 1'b1, d, q);
    endtask

    task automatic rd_chk(input string nm, input logic [3:0] a, input logic [7:0] ex);
        logic [7:0] q;
        bus_op(a, 1'b0, 8'h00, q);
        `CHK(nm, ex, q)
    endtask

    task automatic do_reset;
        sys_rst <= 1'b1;
        idle(5);
        sys_rst <= 1'b0;
    endtask

    // one pulse on the trigger pin (s=1) or the io pin (s=0)
    task automatic pin_pulse(input logic s);
        @(posedge core_clk);
        if (s) trig_lvl <= 1'b1; else io_lvl <= 1'b1;
        idle(8);
        if (s) trig_lvl <= 1'b0; else io_lvl <= 1'b0;
        idle(8);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_regs;
        rd_chk("cnt_lo", PTTC_IDX_CNT_LO, 8'h00);
        rd_chk("cnt_hi", PTTC_IDX_CNT_HI, 8'h00);
        rd_chk("duty_hi", PTTC_IDX_DUTY_HI, 8'h00);
        rd_chk("unmapped", 4'h9, 8'h00);
        wr(PTTC_IDX_PER_HI, 8'hFF);
        rd_chk("per_hi", PTTC_IDX_PER_HI, 8'h03);
        wr(PTTC_IDX_PER_HI, 8'h00);
    endtask

    // period 3 and clear-source set must not shorten the pulse
    task automatic t_pulse(input logic sw);
        int h0;
        int i0;
        logic [7:0] q;
        wr(PTTC_IDX_PER_LO, 8'h03);
        wr(PTTC_IDX_DUTY_LO, 8'h0C);
        wr(PTTC_IDX_CTRL1, 8'hB1);
        h0 = hi_cnt;
        i0 = irq_cnt;
        if (sw) wr(PTTC_IDX_CTRL0, 8'h08);
        else trig_lvl <= 1'b1;
        idle(40);
        `CHK("sp_oe", 1'b1, io_pin_oe)
        `CHK("sp_width", 1'b1, (hi_cnt - h0 >= 12) && (hi_cnt - h0 <= 14))
        `CHK("sp_irq", 1, irq_cnt - i0)
        rd_chk("sp_run", PTTC_IDX_CTRL0, 8'h00);
        rd_chk("sp_flags", PTTC_IDX_FLAGS, 8'h01);
        bus_op(PTTC_IDX_CNT_LO, 1'b0, 8'h00, q);
        idle(20);
        rd_chk("sp_hold", PTTC_IDX_CNT_LO, q);
        wr(PTTC_IDX_FLAGS, 8'h01);
        rd_chk("fl_clr", PTTC_IDX_FLAGS, 8'h00);
        trig_lvl <= 1'b0;
        wr(PTTC_IDX_PER_LO, 8'h00);
    endtask

    // init, polarity and clear-source bits set throughout
    task automatic t_cap(input logic [1:0] act, input logic src, input int ex);
        int i0;
        wr(PTTC_IDX_CTRL1, {2'b01, act, 2'b11, src, 1'b1});
        wr(PTTC_IDX_CTRL0, 8'h08);
        i0 = irq_cnt;
        pin_pulse(~src);
        pin_pulse(src);
        `CHK("cap_irq", ex, irq_cnt - i0)
        `CHK("cap_oe", 1'b0, io_pin_oe)
        wr(PTTC_IDX_CTRL0, 8'h00);
    endtask

    task automatic t_cap_val;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] dd;
        wr(PTTC_IDX_CTRL1, 8'h40);
        wr(PTTC_IDX_CTRL0, 8'h08);
        idle(30);
        bus_op(PTTC_IDX_CNT_LO, 1'b0, 8'h00, c1);
        pin_pulse(1'b0);
        bus_op(PTTC_IDX_DUTY_LO, 1'b0, 8'h00, c2);
        dd = c2 - c1;
        `CHK("cap_val", 1'b1, (dd > 8'h00) && (dd < 8'h0C))
        wr(PTTC_IDX_CTRL0, 8'h00);
    endtask

    task automatic t_period;
        int i0;
        logic [7:0] q;
        wr(PTTC_IDX_PER_LO, 8'h14);
        wr(PTTC_IDX_CTRL1, 8'h70);
        i0 = irq_cnt;
        wr(PTTC_IDX_CTRL0, 8'h08);
        idle(105);
        `CHK("per_irq", 1'b1, (irq_cnt - i0 >= 4) && (irq_cnt - i0 <= 5))
        rd_chk("per_flags", PTTC_IDX_FLAGS, 8'h02);
        bus_op(PTTC_IDX_CNT_LO, 1'b0, 8'h00, q);
        `CHK("per_max", 1'b1, q <= 8'h14)
        wr(PTTC_IDX_CTRL0, 8'h00);
        bus_op(PTTC_IDX_CNT_LO, 1'b0, 8'h00, q);
        idle(10);
        rd_chk("cap_stop", PTTC_IDX_CNT_LO, q);
        wr(PTTC_IDX_PER_LO, 8'h00);
        i0 = irq_cnt;
        wr(PTTC_IDX_CTRL0, 8'h08);
        idle(1030);
        `CHK("per_zero", 1, irq_cnt - i0)
        wr(PTTC_IDX_CTRL0, 8'h00);
    endtask

    task automatic t_pwm;
        int r0;
        wr(PTTC_IDX_PER_LO, 8'h0A);
        wr(PTTC_IDX_DUTY_LO, 8'h03);
        wr(PTTC_IDX_CTRL1, 8'hA1);
        wr(PTTC_IDX_CTRL0, 8'h08);
        idle(5);
        r0 = rise_cnt;
        idle(110);
        `CHK("pwm_rises", 1'b1, (rise_cnt - r0 >= 9) && (rise_cnt - r0 <= 11))
        wr(PTTC_IDX_CTRL1, 8'h81);
        wr(PTTC_IDX_FLAGS, 8'h03);
        idle(30);
        `CHK("pwm_pin", 1'b0, io_pin_out)
        rd_chk("pwm_forced", PTTC_IDX_FLAGS, 8'h03);
        wr(PTTC_IDX_CTRL0, 8'h00);
    endtask

    // ****************************************************************
    // main sequence and verdict
    // ****************************************************************
    task automatic conclude;
        if (error_cnt == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge core_clk);
        error_cnt++;
        conclude();
    end

    initial begin
        do_reset();
        t_regs();
        t_pulse(1'b0);
        t_pulse(1'b1);
        t_cap(2'b00, 1'b0, 1);
        t_cap(2'b01, 1'b0, 1);
        t_cap(2'b10, 1'b0, 2);
        t_cap(2'b11, 1'b0, 0);
        t_cap(2'b00, 1'b1, 1);
        t_cap_val();
        do_reset();
        t_period();
        do_reset();
        t_pwm();
        conclude();
    end
endmodule // tb
